// *** core/cmt_timer.sv ***
/*
 * Eight-bit compare-match timer channel: up counter, two compare
 * constants, clear and output control, arbitration between register
 * writes and timer events, module stop and interrupt flags.
 * Assumes a register master that keeps strobes one cycle long and never
 * raises read and write together; pins are asynchronous.
 */
`timescale 1ns/1ps
module cmt_timer #(
    parameter int unsigned CNT_W = cmt_pkg::CMT_DW
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [cmt_pkg::CMT_AW-1:0] reg_addr_i,
    input  wire logic [cmt_pkg::CMT_DW-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output      logic [cmt_pkg::CMT_DW-1:0] reg_rdata_o,
    input  wire logic                       ext_clk_i,
    input  wire logic                       ext_clr_i,
    output      logic                       timer_out_o,
    output      logic                       irq_o,
    output      logic                       stopped_o
);
    import cmt_pkg::*;

    // ==========================================================
    // Elaboration check
    if (CNT_W < 2 || CNT_W > CMT_DW) begin : g_chk
        $error("cmt_timer: CNT_W must lie between 2 and the bus width");
    end

    // ==========================================================
    // Helpers
    function automatic logic cmp_hit(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] cor,
                                     input logic             pulse,
                                     input logic             cor_wr);
        cmp_hit = pulse & (cnt == cor) & ~cor_wr;
    endfunction

    function automatic logic [1:0] act_rank(input logic [1:0] act);
        case (act)
            CMT_ACT_TOGGLE: act_rank = 2'h3;
            CMT_ACT_ONE:    act_rank = 2'h2;
            CMT_ACT_ZERO:   act_rank = 2'h1;
            default:        act_rank = 2'h0;
        endcase
    endfunction

    // ==========================================================
    // Registers and nets
    cmt_cnt_if cnt_if ();

    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cora_r;
    logic [CNT_W-1:0]      corb_r;
    logic [CMT_DW-1:0]     ctl_r;
    logic [CMT_DW-1:0]     osel_r;
    logic [CMT_FLG_W-1:0]  flag_r;
    logic [CMT_FLG_W-1:0]  ien_r;
    logic                  stop_r;
    logic                  out_r;
    logic                  irq_r;
    logic [CMT_DW-1:0]     rdata_r;

    logic                  acc_ok;
    logic                  wr_cnt;
    logic                  wr_cora;
    logic                  wr_corb;
    logic                  wr_ctl;
    logic                  wr_osel;
    logic                  wr_iclr;
    logic                  wr_ien;
    logic                  wr_stop;
    logic                  hit_a;
    logic                  hit_b;
    logic                  clr_evt;
    logic                  inc;
    logic                  ovf_evt;
    logic [1:0]            cclr;
    logic [1:0]            act_a;
    logic [1:0]            act_b;
    logic [1:0]            act;
    logic                  out_nxt;
    logic [CMT_FLG_W-1:0]  flag_set;
    logic [CMT_FLG_W-1:0]  flag_clr;

    // ==========================================================
    // Count source
    assign cnt_if.clk_sel = ctl_r[CMT_CKS_LSB +: CMT_CKS_W];
    assign cnt_if.run     = ~stop_r;

    cmt_count_src u_src (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .ext_clk_i (ext_clk_i),
        .ext_clr_i (ext_clr_i),
        .cnt_if    (cnt_if.src)
    );

    // ==========================================================
    // Write decode; the strobe cycle is the commit cycle
    assign acc_ok  = ~stop_r;
    assign wr_cnt  = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_CNT);
    assign wr_cora = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_CORA);
    assign wr_corb = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_CORB);
    assign wr_ctl  = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_CTL);
    assign wr_osel = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_OSEL);
    assign wr_iclr = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_ICLR);
    assign wr_ien  = reg_wr_i & acc_ok & (reg_addr_i == CMT_OFS_IEN);
    assign wr_stop = reg_wr_i & (reg_addr_i == CMT_OFS_MSTOP);

    // ==========================================================
    // Event arbitration
    assign cclr  = ctl_r[CMT_CCLR_LSB +: 2];
    assign hit_a = cmp_hit(cnt_r, cora_r, cnt_if.count_pulse, wr_cora);
    assign hit_b = cmp_hit(cnt_r, corb_r, cnt_if.count_pulse, wr_corb);

    always_comb begin
        case (cclr)
            CMT_CCLR_MATCH_A: clr_evt = hit_a;
            CMT_CCLR_MATCH_B: clr_evt = hit_b;
            CMT_CCLR_EXT:     clr_evt = cnt_if.ext_clr_edge;
            default:          clr_evt = 1'b0;
        endcase
    end

    assign inc     = cnt_if.count_pulse & ~clr_evt & ~wr_cnt;
    assign ovf_evt = inc & (&cnt_r);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnt_r <= CMT_RST_ZERO[CNT_W-1:0];
        end else if (clr_evt) begin
            cnt_r <= '0;
        end else if (wr_cnt) begin
            cnt_r <= reg_wdata_i[CNT_W-1:0];
        end else if (inc) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cora_r <= CMT_RST_COR[CNT_W-1:0];
            corb_r <= CMT_RST_COR[CNT_W-1:0];
        end else begin
            if (wr_cora) begin
                cora_r <= reg_wdata_i[CNT_W-1:0];
            end
            if (wr_corb) begin
                corb_r <= reg_wdata_i[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ctl_r  <= CMT_RST_ZERO;
            osel_r <= CMT_RST_ZERO;
            ien_r  <= '0;
        end else begin
            if (wr_ctl) begin
                ctl_r <= reg_wdata_i;
            end
            if (wr_osel) begin
                osel_r <= reg_wdata_i;
            end
            if (wr_ien) begin
                ien_r <= reg_wdata_i[CMT_FLG_W-1:0];
            end
        end
    end

    // Stop takes effect after the cycle that writes it
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            stop_r <= CMT_RST_STOP;
        end else if (wr_stop) begin
            stop_r <= reg_wdata_i[CMT_STOP_BIT];
        end
    end

    // ==========================================================
    // Timer output
    assign act_a = osel_r[CMT_OSA_LSB +: CMT_ACT_W];
    assign act_b = osel_r[CMT_OSB_LSB +: CMT_ACT_W];

    always_comb begin
        if (hit_a && hit_b) begin
            act = (act_rank(act_a) >= act_rank(act_b)) ? act_a : act_b;
        end else if (hit_a) begin
            act = act_a;
        end else if (hit_b) begin
            act = act_b;
        end else begin
            act = CMT_ACT_KEEP;
        end
    end

    always_comb begin
        case (act)
            CMT_ACT_ZERO:   out_nxt = 1'b0;
            CMT_ACT_ONE:    out_nxt = 1'b1;
            CMT_ACT_TOGGLE: out_nxt = ~out_r;
            default:        out_nxt = out_r;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // ==========================================================
    // Interrupt flags; set wins over clear, clear blocked while stopped
    always_comb begin
        flag_set               = '0;
        flag_set[CMT_FLG_CMFA] = hit_a;
        flag_set[CMT_FLG_CMFB] = hit_b;
        flag_set[CMT_FLG_OVF]  = ovf_evt;
        flag_clr               = wr_iclr ? reg_wdata_i[CMT_FLG_W-1:0] : '0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_set | (flag_r & ~flag_clr);
        end
    end

    // Request follows flags and enables, also while stopped
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flag_r & ien_r);
        end
    end

    // ==========================================================
    // Read port; data stand one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rdata_r <= CMT_RST_ZERO;
        end else begin
            rdata_r <= CMT_RST_ZERO;
            if (reg_rd_i) begin
                if (reg_addr_i == CMT_OFS_MSTOP) begin
                    rdata_r[CMT_STOP_BIT] <= stop_r;
                end else if (acc_ok) begin
                    case (reg_addr_i)
                        CMT_OFS_CNT:   rdata_r[CNT_W-1:0]     <= cnt_r;
                        CMT_OFS_CORA:  rdata_r[CNT_W-1:0]     <= cora_r;
                        CMT_OFS_CORB:  rdata_r[CNT_W-1:0]     <= corb_r;
                        CMT_OFS_CTL:   rdata_r                <= ctl_r;
                        CMT_OFS_OSEL:  rdata_r                <= osel_r;
                        CMT_OFS_ISTAT: rdata_r[CMT_FLG_W-1:0] <= flag_r;
                        CMT_OFS_IEN:   rdata_r[CMT_FLG_W-1:0] <= ien_r;
                        default:       rdata_r                <= CMT_RST_ZERO;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata_o = rdata_r;
    assign timer_out_o = out_r;
    assign irq_o       = irq_r;
    assign stopped_o   = stop_r;
endmodule

// *** core/cmt_pkg.sv ***
/*
 * Constants shared by the compare-match timer channel: register offsets,
 * field positions, reset values, mode codes and prescaler taps.
 * Assumes a single 100 MHz system clock and a plain register port.
 */
package cmt_pkg;

    // ==========================================================
    // Bus geometry
    localparam int unsigned CMT_DW = 8;
    localparam int unsigned CMT_AW = 4;

    // ==========================================================
    // Register offsets
    localparam logic [CMT_AW-1:0] CMT_OFS_CNT   = 4'h0;
    localparam logic [CMT_AW-1:0] CMT_OFS_CORA  = 4'h1;
    localparam logic [CMT_AW-1:0] CMT_OFS_CORB  = 4'h2;
    localparam logic [CMT_AW-1:0] CMT_OFS_CTL   = 4'h3;
    localparam logic [CMT_AW-1:0] CMT_OFS_OSEL  = 4'h4;
    localparam logic [CMT_AW-1:0] CMT_OFS_ISTAT = 4'h5;
    localparam logic [CMT_AW-1:0] CMT_OFS_ICLR  = 4'h6;
    localparam logic [CMT_AW-1:0] CMT_OFS_IEN   = 4'h7;
    localparam logic [CMT_AW-1:0] CMT_OFS_MSTOP = 4'h8;

    // ==========================================================
    // Reset values
    localparam logic [CMT_DW-1:0] CMT_RST_ZERO = 8'h00;
    localparam logic [CMT_DW-1:0] CMT_RST_COR  = 8'hff;
    localparam logic              CMT_RST_STOP = 1'b1;

    // ==========================================================
    // Field positions
    localparam int unsigned CMT_CKS_LSB  = 0;
    localparam int unsigned CMT_CKS_W    = 3;
    localparam int unsigned CMT_CCLR_LSB = 3;
    localparam int unsigned CMT_OSA_LSB  = 0;
    localparam int unsigned CMT_OSB_LSB  = 2;
    localparam int unsigned CMT_ACT_W    = 2;
    localparam int unsigned CMT_FLG_CMFA = 0;
    localparam int unsigned CMT_FLG_CMFB = 1;
    localparam int unsigned CMT_FLG_OVF  = 2;
    localparam int unsigned CMT_FLG_W    = 3;
    localparam int unsigned CMT_STOP_BIT = 0;

    // ==========================================================
    // Mode codes
    localparam logic [2:0] CMT_CKS_NONE     = 3'h0;
    localparam logic [2:0] CMT_CKS_DIV8     = 3'h1;
    localparam logic [2:0] CMT_CKS_DIV64    = 3'h2;
    localparam logic [2:0] CMT_CKS_DIV8192  = 3'h3;
    localparam logic [2:0] CMT_CKS_EXT_RISE = 3'h5;
    localparam logic [2:0] CMT_CKS_EXT_FALL = 3'h6;
    localparam logic [2:0] CMT_CKS_EXT_BOTH = 3'h7;

    localparam logic [1:0] CMT_CCLR_NONE  = 2'h0;
    localparam logic [1:0] CMT_CCLR_MATCH_A = 2'h1;
    localparam logic [1:0] CMT_CCLR_MATCH_B = 2'h2;
    localparam logic [1:0] CMT_CCLR_EXT   = 2'h3;

    localparam logic [1:0] CMT_ACT_KEEP   = 2'h0;
    localparam logic [1:0] CMT_ACT_ZERO   = 2'h1;
    localparam logic [1:0] CMT_ACT_ONE    = 2'h2;
    localparam logic [1:0] CMT_ACT_TOGGLE = 2'h3;

    // ==========================================================
    // Prescaler taps (bit n toggles with period 2^(n+1) cycles)
    localparam int unsigned CMT_PRE_W        = 13;
    localparam int unsigned CMT_TAP_DIV8     = 2;
    localparam int unsigned CMT_TAP_DIV64    = 5;
    localparam int unsigned CMT_TAP_DIV8192  = 12;

endpackage

// *** core/cmt_cnt_if.sv ***
/*
 * Link between the timer core and its count-source module.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface cmt_cnt_if;
    logic [2:0] clk_sel;
    logic       run;
    logic       count_pulse;
    logic       ext_clr_edge;

    modport src  (input clk_sel, input run, output count_pulse, output ext_clr_edge);
    modport core (output clk_sel, output run, input count_pulse, input ext_clr_edge);
endinterface

// *** core/cmt_count_src.sv ***
/*
 * Count source: prescaler, clock select and edge detection, plus the
 * synchronised external clear edge.
 * Assumes ext_clk_i and ext_clr_i are asynchronous pins.
 */
`timescale 1ns/1ps
module cmt_count_src (
    input  wire logic     ref_clk_i,
    input  wire logic     rst_b_i,
    input  wire logic     ext_clk_i,
    input  wire logic     ext_clr_i,
    cmt_cnt_if.src        cnt_if
);
    import cmt_pkg::*;

    logic [CMT_PRE_W-1:0] pre_r;
    logic [2:0]           clk_sync_r;
    logic [2:0]           clr_sync_r;
    logic                 sel_level;
    logic                 sel_level_r;
    logic                 fall;
    logic                 rise;

    // ==========================================================
    // Prescaler and pin synchronisers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            clk_sync_r <= '0;
            clr_sync_r <= '0;
        end else begin
            clk_sync_r <= {clk_sync_r[1:0], ext_clk_i};
            clr_sync_r <= {clr_sync_r[1:0], ext_clr_i};
        end
    end

    // ==========================================================
    // Selected level; one tracked level for all sources, so a change of
    // selection that goes high to low looks like a falling edge
    always_comb begin
        case (cnt_if.clk_sel)
            CMT_CKS_DIV8:     sel_level = pre_r[CMT_TAP_DIV8];
            CMT_CKS_DIV64:    sel_level = pre_r[CMT_TAP_DIV64];
            CMT_CKS_DIV8192:  sel_level = pre_r[CMT_TAP_DIV8192];
            CMT_CKS_EXT_RISE,
            CMT_CKS_EXT_FALL,
            CMT_CKS_EXT_BOTH: sel_level = clk_sync_r[1];
            default:          sel_level = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sel_level_r <= 1'b0;
        end else begin
            sel_level_r <= sel_level;
        end
    end

    assign fall = sel_level_r & ~sel_level;
    assign rise = ~sel_level_r & sel_level;

    always_comb begin
        case (cnt_if.clk_sel)
            CMT_CKS_EXT_RISE: cnt_if.count_pulse = cnt_if.run & rise;
            CMT_CKS_EXT_BOTH: cnt_if.count_pulse = cnt_if.run & (rise | fall);
            default:          cnt_if.count_pulse = cnt_if.run & fall;
        endcase
    end

    assign cnt_if.ext_clr_edge = cnt_if.run & clr_sync_r[1] & ~clr_sync_r[2];
endmodule

// *** tb/cmt_timer_properties.sv ***
/*
 * Port checker for the compare-match timer channel.
 * Assumes it is bound to cmt_timer and sees only that module's ports.
 */
`timescale 1ns/1ps
module cmt_timer_properties (
    input wire logic                       ref_clk_i,
    input wire logic                       rst_b_i,
    input wire logic [cmt_pkg::CMT_AW-1:0] reg_addr_i,
    input wire logic [cmt_pkg::CMT_DW-1:0] reg_wdata_i,
    input wire logic                       reg_wr_i,
    input wire logic                       reg_rd_i,
    input wire logic [cmt_pkg::CMT_DW-1:0] reg_rdata_o,
    input wire logic                       timer_out_o,
    input wire logic                       irq_o,
    input wire logic                       stopped_o
);
    import cmt_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ==========================================================
    // Reset, stop and register port
    property p_rst;
        disable iff (1'b0) !rst_b_i |=> stopped_o && !irq_o && !timer_out_o && reg_rdata_o == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_stop_set;
        reg_wr_i && reg_addr_i == CMT_OFS_MSTOP && reg_wdata_i[0] |=> stopped_o;
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop not entered");
    property p_stop_clr;
        reg_wr_i && reg_addr_i == CMT_OFS_MSTOP && !reg_wdata_i[0] |=> !stopped_o;
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop not left");
    property p_stop_blk;
        stopped_o && reg_rd_i && reg_addr_i != CMT_OFS_MSTOP |=> reg_rdata_o == 8'h00;
    endproperty
    a_stop_blk: assert property (p_stop_blk) else $error("read while stopped");
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_stop_rd;
        reg_rd_i && reg_addr_i == CMT_OFS_MSTOP |=> reg_rdata_o == {7'h00, $past(stopped_o)};
    endproperty
    a_stop_rd: assert property (p_stop_rd) else $error("stop bit reads wrong");
    property p_cor_rb;
        reg_wr_i && reg_addr_i == CMT_OFS_CORA && !stopped_o ##1 reg_rd_i && reg_addr_i == CMT_OFS_CORA
            |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_cor_rb: assert property (p_cor_rb) else $error("compare write not committed");

    // ==========================================================
    // Behaviour while stopped
    property p_irq_stuck;
        stopped_o && irq_o |=> irq_o;
    endproperty
    a_irq_stuck: assert property (p_irq_stuck) else $error("request dropped in stop");
    property p_out_hold;
        stopped_o [*2] |=> $stable(timer_out_o);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved in stop");
endmodule

// *** tb/cmt_pin_model.sv ***
/*
 * External pin driver for the timer's count and clear inputs.
 * Assumes the bench calls its tasks from a clocked sequence.
 */
`timescale 1ns/1ps
module cmt_pin_model (
    input  wire logic ref_clk_i,
    output      logic ext_clk_o,
    output      logic ext_clr_o
);
    initial begin
        ext_clk_o = 1'b0;
        ext_clr_o = 1'b0;
    end
    // Each level held four cycles, well above the minimum pulse width
    task automatic clk_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            ext_clk_o <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            ext_clk_o <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask
    task automatic clk_hold(input logic lv);
        ext_clk_o <= lv;
    endtask
    task automatic clr_pulse;
        ext_clr_o <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        ext_clr_o <= 1'b0;
    endtask
endmodule

// *** tb/test_cmt_timer.sv ***
/*
 * Self-checking bench for the compare-match timer channel.
 * Assumes cmt_pkg, cmt_cnt_if, cmt_count_src and cmt_timer are compiled first.
 */
`timescale 1ns/1ps
module test_cmt_timer;
    import cmt_pkg::*;
    logic              ref_clk_i;
    logic              rst_b_i;
    logic [CMT_AW-1:0] reg_addr_i;
    logic [CMT_DW-1:0] reg_wdata_i;
    logic              reg_wr_i;
    logic              reg_rd_i;
    logic [CMT_DW-1:0] reg_rdata_o;
    logic              ext_clk_i;
    logic              ext_clr_i;
    logic              timer_out_o;
    logic              irq_o;
    logic              stopped_o;
    logic              rd_d = 1'b0;
    logic              out_m = 1'b0;
    logic [7:0]        exq[$];
    logic [7:0]        a;
    logic [7:0]        b;
    logic [7:0]        v;
    int                bad_count = 0;
    int                num_checks = 0;
    int                c;

    cmt_timer u_cmt_timer (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ext_clk_i(ext_clk_i), .ext_clr_i(ext_clr_i), .timer_out_o(timer_out_o), .irq_o(irq_o),
        .stopped_o(stopped_o));
    cmt_pin_model u_cmt_pin_model (.ref_clk_i(ref_clk_i), .ext_clk_o(ext_clk_i), .ext_clr_o(ext_clr_i));

    // ==========================================================
    // Bus tasks and checking
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        exq.push_back(e);
        reg_addr_i <= ad;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask
    task automatic idle(input int n);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic meas(input logic lv);
        c = 0;
        while (timer_out_o !== lv && c < 300) begin
            @(posedge ref_clk_i);
            c++;
        end
    endtask
    function automatic logic act(input logic o, input logic [1:0] x, input logic [1:0] y);
        logic [1:0] w;
        w = (x > y) ? x : y;
        return (w == CMT_ACT_TOGGLE) ? ~o : (w == CMT_ACT_ONE) ? 1'b1 : (w == CMT_ACT_ZERO) ? 1'b0 : o;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (rd_d) begin
            chk("rdata", reg_rdata_o, exq.pop_front());
        end
        rd_d <= reg_rd_i;
    end

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        tally_and_finish;
    end

    // ==========================================================
    // Test sequence
    initial begin
        rst_b_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        void'($urandom(32'h46ad93c6));
        repeat (16) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        idle(1);
        chk("stopped", 8'(stopped_o), 8'h01);
        rd(CMT_OFS_CORA, 8'h00);
        wr(CMT_OFS_CORA, 8'h55);
        wr(CMT_OFS_MSTOP, 8'h00);
        rd(CMT_OFS_MSTOP, 8'h00);
        rd(CMT_OFS_CORA, CMT_RST_COR);
        rd(CMT_OFS_CORB, CMT_RST_COR);
        rd(CMT_OFS_CNT, CMT_RST_ZERO);
        rd(4'hf, 8'h00);
        idle(2);
        $display("test reset_stop done");
        wr(CMT_OFS_CORA, 8'h02);
        wr(CMT_OFS_CORB, 8'h02);
        for (int i = 0; i < 16; i++) begin
            wr(CMT_OFS_CNT, 8'h00);
            wr(CMT_OFS_OSEL, 8'(i));
            wr(CMT_OFS_CTL, {5'h00, CMT_CKS_DIV8});
            idle(40);
            wr(CMT_OFS_CTL, 8'h00);
            idle(1);
            out_m = act(out_m, i[1:0], i[3:2]);
            chk("out", 8'(timer_out_o), 8'(out_m));
        end
        $display("test match_priority done");
        wr(CMT_OFS_CTL, {5'h00, CMT_CKS_DIV8});
        for (int k = 0; k < 8; k++) begin
            v = 8'($urandom_range(8'hf0));
            wr(CMT_OFS_CNT, v);
            rd(CMT_OFS_CNT, v);
            idle(7);
        end
        $display("test write_vs_count done");
        // Halt and zero the counter and drop stale flags before the pulse run
        wr(CMT_OFS_CTL, 8'h00);
        wr(CMT_OFS_CNT, 8'h00);
        wr(CMT_OFS_ICLR, 8'h07);
        a = 8'(3 + $urandom_range(5));
        b = 8'($urandom_range(2));
        wr(CMT_OFS_CORA, a);
        rd(CMT_OFS_CORA, a);
        wr(CMT_OFS_CORB, b);
        wr(CMT_OFS_OSEL, 8'h06);
        wr(CMT_OFS_IEN, 8'h01);
        wr(CMT_OFS_CTL, {3'h0, CMT_CCLR_MATCH_A, CMT_CKS_DIV8});
        idle(1);
        meas(1'b0);
        meas(1'b1);
        meas(1'b0);
        chk("high", 8'(c), 8'((b + 1) * 8));
        meas(1'b1);
        chk("low", 8'(c), 8'((a - b) * 8));
        chk("irq", 8'(irq_o), 8'h01);
        wr(CMT_OFS_MSTOP, 8'h01);
        wr(CMT_OFS_ICLR, 8'h07);
        idle(4);
        chk("irq", 8'(irq_o), 8'h01);
        wr(CMT_OFS_MSTOP, 8'h00);
        wr(CMT_OFS_CTL, 8'h00);
        wr(CMT_OFS_CNT, 8'h00);
        idle(4);
        rd(CMT_OFS_ISTAT, 8'h03);
        wr(CMT_OFS_ICLR, 8'h07);
        idle(2);
        chk("irq", 8'(irq_o), 8'h00);
        // Enables dropped before stopping so no request is left stuck
        wr(CMT_OFS_IEN, 8'h00);
        rd(CMT_OFS_ISTAT, 8'h00);
        idle(2);
        $display("test pulse_irq done");
        wr(CMT_OFS_CTL, {3'h0, CMT_CCLR_EXT, CMT_CKS_EXT_RISE});
        wr(CMT_OFS_CNT, 8'h00);
        idle(1);
        u_cmt_pin_model.clk_pulses(5);
        idle(8);
        rd(CMT_OFS_CNT, 8'h05);
        idle(1);
        fork
            u_cmt_pin_model.clr_pulse;
            begin
                // Counter write lands on the edge where the synchronised clear acts
                idle(2);
                wr(CMT_OFS_CNT, 8'h33);
                idle(1);
            end
        join
        idle(8);
        rd(CMT_OFS_CNT, 8'h00);
        // Pin held high in falling-edge mode, then the source is switched under it
        wr(CMT_OFS_CTL, {3'h0, CMT_CCLR_NONE, CMT_CKS_EXT_FALL});
        wr(CMT_OFS_CNT, 8'h00);
        u_cmt_pin_model.clk_hold(1'b1);
        idle(4);
        // Divide-by-8192 tap is still low this early after reset
        wr(CMT_OFS_CTL, {3'h0, CMT_CCLR_NONE, CMT_CKS_DIV8192});
        idle(2);
        rd(CMT_OFS_CNT, 8'h01);
        wr(CMT_OFS_CTL, {3'h0, CMT_CCLR_NONE, CMT_CKS_EXT_FALL});
        idle(1);
        wr(CMT_OFS_CTL, 8'h00);
        idle(2);
        rd(CMT_OFS_CNT, 8'h02);
        u_cmt_pin_model.clk_hold(1'b0);
        wr(CMT_OFS_MSTOP, 8'h01);
        idle(3);
        chk("irq", 8'(irq_o), 8'h00);
        $display("test ext_pins done");
        tally_and_finish;
    end
endmodule

bind cmt_timer cmt_timer_properties u_cmt_timer_properties (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .timer_out_o(timer_out_o), .irq_o(irq_o), .stopped_o(stopped_o));
